// File: inc/vic_pkg.sv
// Purpose: Shared constants and types of the vectored interrupt controller.
// Assumes: 8-bit special-function-register bus with 8-bit addresses.
// Notes: Source slots are indexed by the fixed source number; slots 5, 6 and 15 are empty.
package vic_pkg;
    typedef logic [7:0] vic_byte_t;
    typedef logic [3:0] vic_num_t;
    typedef logic [15:0] vic_vec_t;
    typedef logic [15:0] vic_slot_t;

    // Register addresses.
    localparam vic_byte_t ADDR_TIMER_CTRL = 8'h88;
    localparam vic_byte_t ADDR_EXT_FLAG = 8'h91;
    localparam vic_byte_t ADDR_EN_BASIC = 8'ha8;
    localparam vic_byte_t ADDR_LVL_BASIC = 8'hb8;
    localparam vic_byte_t ADDR_EXT_CTRL = 8'hd8;
    localparam vic_byte_t ADDR_EN_EXT = 8'he8;
    localparam vic_byte_t ADDR_LVL_EXT = 8'hf8;

    // Reset values and masks of implemented bits; other bits read as zero.
    localparam vic_byte_t REG_RESET = 8'h00;
    localparam vic_byte_t MASK_EN_BASIC = 8'hdf;
    localparam vic_byte_t MASK_LVL_BASIC = 8'h5f;
    localparam vic_byte_t MASK_EXT = 8'h7f;

    // Basic enable and level field positions.
    localparam int GATE_BIT = 7;
    localparam int B_UART1 = 6;
    localparam int B_UART0 = 4;
    localparam int B_TIMER1 = 3;
    localparam int B_PIN1 = 2;
    localparam int B_TIMER0 = 1;
    localparam int B_PIN0 = 0;
    // Extended enable and level field positions.
    localparam int X_VOICE = 6;
    localparam int X_SERIAL = 5;
    localparam int X_SLEEP = 4;
    localparam int X_TIMER3 = 3;
    localparam int X_CIPHER = 2;
    localparam int X_TIMER2 = 1;
    localparam int X_RADIO = 0;
    // Flag positions in the timer control, extended flag and extended control registers.
    localparam int T_TIMER1 = 7;
    localparam int T_TIMER0 = 5;
    localparam int T_PIN1 = 3;
    localparam int T_PIN0 = 1;
    localparam int F_TIMER3 = 7;
    localparam int F_CIPHER = 6;
    localparam int F_TIMER2 = 5;
    localparam int F_RADIO = 4;
    localparam int C_SLEEP = 3;
    localparam int UART_REQ_BIT = 0;

    // Fixed source numbers.
    localparam vic_num_t SRC_PIN0 = 4'h0;
    localparam vic_num_t SRC_TIMER0 = 4'h1;
    localparam vic_num_t SRC_PIN1 = 4'h2;
    localparam vic_num_t SRC_TIMER1 = 4'h3;
    localparam vic_num_t SRC_UART0 = 4'h4;
    localparam vic_num_t SRC_UART1 = 4'h7;
    localparam vic_num_t SRC_RADIO = 4'h8;
    localparam vic_num_t SRC_TIMER2 = 4'h9;
    localparam vic_num_t SRC_CIPHER = 4'ha;
    localparam vic_num_t SRC_TIMER3 = 4'hb;
    localparam vic_num_t SRC_SLEEP = 4'hc;
    localparam vic_num_t SRC_SERIAL = 4'hd;
    localparam vic_num_t SRC_VOICE = 4'he;
    localparam int NUM_SLOTS = 16;
    localparam int NUM_SOURCES = 13;
    localparam int VOICE_SOURCES = 24;

    // Service routine address for each slot; empty slots hold zero.
    localparam vic_vec_t VEC_ADDR [NUM_SLOTS] = '{
        16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h0000, 16'h0000, 16'h003b,
        16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h0068, 16'h0073, 16'h0000};
endpackage

// File: rtl/vic_pick.sv
// Purpose: Finds the lowest set bit of a request set.
// Assumes: Purely combinational; the caller registers the result.
// Notes: Used once for each priority level.
`timescale 1ns/1ps
module vic_pick #(
    parameter int N = 16,
    parameter int W = 4
) (
    input wire logic [N-1:0] req,
    output logic any,
    output logic [W-1:0] idx
);
    // Scan from the top down so the lowest number is the last to be taken.
    always_comb begin
        any = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = W'(i);
            end
        end
    end
endmodule // vic_pick

// File: rtl/vic_top.sv
// Purpose: Vectored interrupt controller for the core, with flag, enable and level registers.
// Assumes: Core pulses IRQ_ACK on entry to a routine and IRQ_RETI on its return.
// Notes: Register reads answer in the cycle after the read strobe.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module vic_top
    import vic_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire vic_pkg::vic_byte_t ADDR,
    input wire vic_pkg::vic_byte_t WDATA,
    input wire logic WR,
    input wire logic RD,
    output vic_pkg::vic_byte_t RDATA,
    input wire logic PIN0_IRQ_N,
    input wire logic PIN1_IRQ_N,
    input wire logic TIMER0_OVF,
    input wire logic TIMER1_OVF,
    input wire logic TIMER2_EVT,
    input wire logic TIMER3_EVT,
    input wire logic RADIO_EVT,
    input wire logic CIPHER_EVT,
    input wire logic SLEEP_EVT,
    input wire logic [3:0] UART0_IDENT,
    input wire logic [3:0] UART1_IDENT,
    input wire logic SERIAL_LOCAL_EN,
    input wire logic SERIAL_DONE,
    input wire logic [VOICE_SOURCES-1:0] VOICE_EN,
    input wire logic [VOICE_SOURCES-1:0] VOICE_FLAG,
    input wire logic IRQ_ACK,
    input wire logic IRQ_RETI,
    output logic IRQ_REQ,
    output vic_pkg::vic_num_t IRQ_NUM,
    output vic_pkg::vic_vec_t IRQ_VECTOR,
    output logic IRQ_LEVEL,
    output logic [2:0] IRQ_CAUSE
);
    import vic_pkg::*;

    vic_byte_t en_basic_q;
    vic_byte_t lvl_basic_q;
    vic_byte_t en_ext_q;
    vic_byte_t lvl_ext_q;
    vic_byte_t tctl_q;
    vic_byte_t xflag_q;
    vic_byte_t xctl_q;
    vic_byte_t rdata_d;
    vic_byte_t rdata_q;
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_s3_q;
    logic [1:0] pin_fall;
    vic_slot_t src_req;
    vic_slot_t src_en;
    vic_slot_t src_lvl;
    vic_slot_t elig;
    vic_slot_t hi_set;
    vic_slot_t lo_set;
    vic_slot_t win_set_q;
    logic hi_any;
    logic lo_any;
    vic_num_t hi_idx;
    vic_num_t lo_idx;
    logic win_hi;
    logic win_lo;
    logic take;
    logic ins_hi_q;
    logic ins_lo_q;
    logic req_q;
    vic_num_t num_q;
    vic_vec_t vec_q;
    logic lvl_q;
    logic [2:0] cause_q;
    logic wr_tctl;
    logic wr_xflag;
    logic wr_xctl;

    // The pins cross in through two flip-flops; a third stage feeds the falling edge detector.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_s1_q <= 2'h3;
            pin_s2_q <= 2'h3;
            pin_s3_q <= 2'h3;
        end else begin
            pin_s1_q <= {PIN1_IRQ_N, PIN0_IRQ_N};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    assign pin_fall = pin_s3_q & ~pin_s2_q;

    // Write decodes for the flag registers.
    assign wr_tctl = WR && (ADDR == ADDR_TIMER_CTRL);
    assign wr_xflag = WR && (ADDR == ADDR_EXT_FLAG);
    assign wr_xctl = WR && (ADDR == ADDR_EXT_CTRL);

    // Enable and level registers; reserved bits are never stored.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            en_basic_q <= REG_RESET;
            lvl_basic_q <= REG_RESET;
            en_ext_q <= REG_RESET;
            lvl_ext_q <= REG_RESET;
        end else if (WR) begin
            if (ADDR == ADDR_EN_BASIC) begin
                en_basic_q <= WDATA & MASK_EN_BASIC;
            end
            if (ADDR == ADDR_LVL_BASIC) begin
                lvl_basic_q <= WDATA & MASK_LVL_BASIC;
            end
            if (ADDR == ADDR_EN_EXT) begin
                en_ext_q <= WDATA & MASK_EXT;
            end
            if (ADDR == ADDR_LVL_EXT) begin
                lvl_ext_q <= WDATA & MASK_EXT;
            end
        end
    end

    // Timer control flags: software may write them, entry clears the timer ones, events set and win.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            tctl_q <= REG_RESET;
        end else begin
            for (int b = 0; b < 8; b++) begin
                if (b == T_TIMER1 || b == T_TIMER0 || b == T_PIN1 || b == T_PIN0) begin
                    if (wr_tctl) begin
                        tctl_q[b] <= WDATA[b];
                    end else if (take && b == T_TIMER0 && num_q == SRC_TIMER0) begin
                        tctl_q[b] <= 1'b0;
                    end else if (take && b == T_TIMER1 && num_q == SRC_TIMER1) begin
                        tctl_q[b] <= 1'b0;
                    end
                end
            end
            if (TIMER0_OVF) begin
                tctl_q[T_TIMER0] <= 1'b1;
            end
            if (TIMER1_OVF) begin
                tctl_q[T_TIMER1] <= 1'b1;
            end
            if (pin_fall[0]) begin
                tctl_q[T_PIN0] <= 1'b1;
            end
            if (pin_fall[1]) begin
                tctl_q[T_PIN1] <= 1'b1;
            end
        end
    end

    // Extended flag and extended control flags; an event in the cycle of a write still sets.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            xflag_q <= REG_RESET;
            xctl_q <= REG_RESET;
        end else begin
            if (wr_xflag) begin
                xflag_q[F_TIMER3] <= WDATA[F_TIMER3];
                xflag_q[F_CIPHER] <= WDATA[F_CIPHER];
                xflag_q[F_TIMER2] <= WDATA[F_TIMER2];
                xflag_q[F_RADIO] <= WDATA[F_RADIO];
            end
            if (wr_xctl) begin
                xctl_q[C_SLEEP] <= WDATA[C_SLEEP];
            end
            if (TIMER3_EVT) begin
                xflag_q[F_TIMER3] <= 1'b1;
            end
            if (CIPHER_EVT) begin
                xflag_q[F_CIPHER] <= 1'b1;
            end
            if (TIMER2_EVT) begin
                xflag_q[F_TIMER2] <= 1'b1;
            end
            if (RADIO_EVT) begin
                xflag_q[F_RADIO] <= 1'b1;
            end
            if (SLEEP_EVT) begin
                xctl_q[C_SLEEP] <= 1'b1;
            end
        end
    end

    // Gather the thirteen requests, enables and levels into slots by source number.
    always_comb begin
        src_req = '0;
        src_en = '0;
        src_lvl = '0;
        src_req[SRC_PIN0] = tctl_q[T_PIN0];
        src_req[SRC_TIMER0] = tctl_q[T_TIMER0];
        src_req[SRC_PIN1] = tctl_q[T_PIN1];
        src_req[SRC_TIMER1] = tctl_q[T_TIMER1];
        src_req[SRC_UART0] = UART0_IDENT[UART_REQ_BIT];
        src_req[SRC_UART1] = UART1_IDENT[UART_REQ_BIT];
        src_req[SRC_RADIO] = xflag_q[F_RADIO];
        src_req[SRC_TIMER2] = xflag_q[F_TIMER2];
        src_req[SRC_CIPHER] = xflag_q[F_CIPHER];
        src_req[SRC_TIMER3] = xflag_q[F_TIMER3];
        src_req[SRC_SLEEP] = xctl_q[C_SLEEP];
        src_req[SRC_SERIAL] = SERIAL_LOCAL_EN && SERIAL_DONE;
        src_req[SRC_VOICE] = |(VOICE_EN & VOICE_FLAG);
        src_en[SRC_PIN0] = en_basic_q[B_PIN0];
        src_en[SRC_TIMER0] = en_basic_q[B_TIMER0];
        src_en[SRC_PIN1] = en_basic_q[B_PIN1];
        src_en[SRC_TIMER1] = en_basic_q[B_TIMER1];
        src_en[SRC_UART0] = en_basic_q[B_UART0];
        src_en[SRC_UART1] = en_basic_q[B_UART1];
        src_en[SRC_RADIO] = en_ext_q[X_RADIO];
        src_en[SRC_TIMER2] = en_ext_q[X_TIMER2];
        src_en[SRC_CIPHER] = en_ext_q[X_CIPHER];
        src_en[SRC_TIMER3] = en_ext_q[X_TIMER3];
        src_en[SRC_SLEEP] = en_ext_q[X_SLEEP];
        src_en[SRC_SERIAL] = en_ext_q[X_SERIAL];
        src_en[SRC_VOICE] = en_ext_q[X_VOICE];
        src_lvl[SRC_PIN0] = lvl_basic_q[B_PIN0];
        src_lvl[SRC_TIMER0] = lvl_basic_q[B_TIMER0];
        src_lvl[SRC_PIN1] = lvl_basic_q[B_PIN1];
        src_lvl[SRC_TIMER1] = lvl_basic_q[B_TIMER1];
        src_lvl[SRC_UART0] = lvl_basic_q[B_UART0];
        src_lvl[SRC_UART1] = lvl_basic_q[B_UART1];
        src_lvl[SRC_RADIO] = lvl_ext_q[X_RADIO];
        src_lvl[SRC_TIMER2] = lvl_ext_q[X_TIMER2];
        src_lvl[SRC_CIPHER] = lvl_ext_q[X_CIPHER];
        src_lvl[SRC_TIMER3] = lvl_ext_q[X_TIMER3];
        src_lvl[SRC_SLEEP] = lvl_ext_q[X_SLEEP];
        src_lvl[SRC_SERIAL] = lvl_ext_q[X_SERIAL];
        src_lvl[SRC_VOICE] = lvl_ext_q[X_VOICE];
    end

    // A source is eligible only with the global gate and its own enable both set.
    assign elig = src_req & src_en & {NUM_SLOTS{en_basic_q[GATE_BIT]}};
    assign hi_set = elig & src_lvl;
    assign lo_set = elig & ~src_lvl;

    // Lowest number wins inside each level.
    vic_pick #(.N(NUM_SLOTS), .W(4)) u_pick_hi (
        .req(hi_set),
        .any(hi_any),
        .idx(hi_idx)
    );
    vic_pick #(.N(NUM_SLOTS), .W(4)) u_pick_lo (
        .req(lo_set),
        .any(lo_any),
        .idx(lo_idx)
    );

    // High may interrupt a low routine; nothing interrupts a high one, and low waits for any routine.
    assign win_hi = hi_any && !ins_hi_q;
    assign win_lo = !win_hi && lo_any && !ins_hi_q && !ins_lo_q;
    assign take = IRQ_ACK && req_q;

    // Request, number, vector and level are registered together so the core sees one consistent set.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            req_q <= 1'b0;
            num_q <= SRC_PIN0;
            vec_q <= VEC_ADDR[SRC_PIN0];
            lvl_q <= 1'b0;
            win_set_q <= '0;
        end else begin
            req_q <= (win_hi || win_lo) && !take;
            if (win_hi) begin
                num_q <= hi_idx;
                vec_q <= VEC_ADDR[hi_idx];
                lvl_q <= 1'b1;
                win_set_q <= hi_set;
            end else if (win_lo) begin
                num_q <= lo_idx;
                vec_q <= VEC_ADDR[lo_idx];
                lvl_q <= 1'b0;
                win_set_q <= lo_set;
            end
        end
    end

    // Track routines in service per level so a return reopens the right level.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ins_hi_q <= 1'b0;
            ins_lo_q <= 1'b0;
        end else if (take) begin
            if (lvl_q) begin
                ins_hi_q <= 1'b1;
            end else begin
                ins_lo_q <= 1'b1;
            end
        end else if (IRQ_RETI) begin
            if (ins_hi_q) begin
                ins_hi_q <= 1'b0;
            end else begin
                ins_lo_q <= 1'b0;
            end
        end
    end

    // Latch the UART cause bits at entry so the routine can tell its cause apart.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cause_q <= 3'h0;
        end else if (take && num_q == SRC_UART0) begin
            cause_q <= UART0_IDENT[3:1];
        end else if (take && num_q == SRC_UART1) begin
            cause_q <= UART1_IDENT[3:1];
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        case (ADDR)
            ADDR_EN_BASIC: rdata_d = en_basic_q;
            ADDR_LVL_BASIC: rdata_d = lvl_basic_q;
            ADDR_EN_EXT: rdata_d = en_ext_q;
            ADDR_LVL_EXT: rdata_d = lvl_ext_q;
            ADDR_TIMER_CTRL: rdata_d = tctl_q;
            ADDR_EXT_FLAG: rdata_d = xflag_q;
            ADDR_EXT_CTRL: rdata_d = xctl_q;
            default: rdata_d = REG_RESET;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= REG_RESET;
        end else begin
            rdata_q <= RD ? rdata_d : REG_RESET;
        end
    end

    assign RDATA = rdata_q;
    assign IRQ_REQ = req_q;
    assign IRQ_NUM = num_q;
    assign IRQ_VECTOR = vec_q;
    assign IRQ_LEVEL = lvl_q;
    assign IRQ_CAUSE = cause_q;

    // Entry of a low routine, followed by a return with no high routine open.
    sequence s_low_entry;
        take && !lvl_q;
    endsequence
    sequence s_low_return;
        IRQ_RETI && !ins_hi_q && !take;
    endsequence

    a_entry_drops_req: assert property (@(posedge CLK) disable iff (!RST_B)
        take |=> !IRQ_REQ) else $error("Request stayed up after entry.");

    a_low_entry_return: assert property (@(posedge CLK) disable iff (!RST_B)
        s_low_entry ##[1:300] s_low_return |=> !ins_lo_q) else $error("Low routine not closed on return.");

    a_vector_table: assert property (@(posedge CLK) disable iff (!RST_B)
        IRQ_REQ |-> (IRQ_VECTOR == VEC_ADDR[IRQ_NUM]) && (IRQ_VECTOR != 16'h0000))
        else $error("Vector does not match source number.");

    a_lowest_wins: assert property (@(posedge CLK) disable iff (!RST_B)
        IRQ_REQ |-> win_set_q[IRQ_NUM] && ((win_set_q & ((16'h0001 << IRQ_NUM) - 16'h0001)) == 16'h0000))
        else $error("A lower numbered source was passed over.");

    a_gate_blocks: assert property (@(posedge CLK) disable iff (!RST_B)
        !en_basic_q[GATE_BIT] |=> !IRQ_REQ) else $error("Request raised with global gate low.");

    a_enable_needed: assert property (@(posedge CLK) disable iff (!RST_B)
        IRQ_REQ |-> ((($past(src_en) >> IRQ_NUM) & 16'h0001) != 16'h0000)) else $error("Disabled source requested.");

    a_high_blocks: assert property (@(posedge CLK) disable iff (!RST_B)
        ins_hi_q && $past(ins_hi_q) |-> !IRQ_REQ) else $error("Request during a high routine.");

    a_low_waits: assert property (@(posedge CLK) disable iff (!RST_B)
        ins_lo_q && $past(ins_lo_q) && IRQ_REQ |-> IRQ_LEVEL) else $error("Low request inside low routine.");

    a_timer_clear: assert property (@(posedge CLK) disable iff (!RST_B)
        take && num_q == SRC_TIMER0 && !TIMER0_OVF && !wr_tctl |=> !tctl_q[T_TIMER0])
        else $error("Timer flag not cleared on entry.");

    a_flag_sets: assert property (@(posedge CLK) disable iff (!RST_B)
        TIMER2_EVT |=> xflag_q[F_TIMER2]) else $error("Event did not set its flag.");

    a_serial_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        !SERIAL_LOCAL_EN |-> !src_req[SRC_SERIAL]) else $error("Serial request without local enable.");

    a_voice_or: assert property (@(posedge CLK) disable iff (!RST_B)
        src_req[SRC_VOICE] == ((VOICE_EN & VOICE_FLAG) != '0)) else $error("Voice request mismatch.");

    a_enable_read: assert property (@(posedge CLK) disable iff (!RST_B)
        RD && ADDR == ADDR_EN_BASIC |=> RDATA == ($past(en_basic_q) & MASK_EN_BASIC))
        else $error("Enable register read wrong.");
endmodule // vic_top

// File: verif/vic_core_model.sv
// Purpose: Behavioural core that enters and leaves service routines of the controller.
// Assumes: Requests are sampled on rising edges; ret_go is a one-cycle command from the bench.
// Notes: Entry waits lat cycles of a standing request; open routine levels are kept in a queue.
`timescale 1ns/1ps
module vic_core_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic irq_req,
    input wire logic irq_level,
    input wire logic [1:0] lat,
    input wire logic ret_go,
    output logic irq_ack,
    output logic irq_reti
);
    int wait_q;
    bit open_q[$];

    // Enters a routine after the chosen latency and returns only when one is open.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_ack <= 1'b0;
            irq_reti <= 1'b0;
            wait_q <= 0;
            open_q.delete();
        end else begin
            irq_ack <= 1'b0;
            irq_reti <= ret_go && open_q.size() > 0;
            if (ret_go && open_q.size() > 0) open_q.pop_back();
            if (irq_req && !irq_ack) begin
                if (wait_q >= lat) begin
                    irq_ack <= 1'b1;
                    open_q.push_back(irq_level);
                    wait_q <= 0;
                end else wait_q <= wait_q + 1;
            end else wait_q <= 0;
        end
    end
endmodule // vic_core_model

// File: verif/tb_vectored_interrupt_controller.sv
// Purpose: Self-checking bench of the vectored interrupt controller.
// Assumes: Core side is the behavioural core model; peripherals are driven here.
// Notes: Expected vectors come from the bench's own table; expected levels are given with each expected request.
`timescale 1ns/1ps
module tb_vectored_interrupt_controller;
    import vic_pkg::*;
    logic clk = 0, rst_b = 0, wr = 0, rd = 0, pin0_n = 1, pin1_n = 1, ret_go = 0, sl_en = 0, sl_done = 0;
    vic_byte_t addr = 8'h00, wdata = 8'h00, rdata, d;
    logic [6:0] evt = 7'h00;
    logic [3:0] u0 = 4'h0, u1 = 4'h0;
    logic [23:0] v_en = 24'h0, v_fl = 24'h0, v;
    logic [1:0] lat = 2'h0;
    logic [2:0] uc;
    logic ack, reti, req, lvl;
    vic_num_t num;
    vic_vec_t vec;
    logic [2:0] cause;
    int n_fail = 0, compares = 0, cyc = 0, s;
    int srcs[13] = '{0, 1, 2, 3, 4, 7, 8, 9, 10, 11, 12, 13, 14};
    logic [7:0] vtab[15] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h00, 8'h00, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b,
        8'h63, 8'h68, 8'h73};
    logic [6:0] emap[15] = '{7'h00, 7'h01, 7'h00, 7'h02, 7'h00, 7'h00, 7'h00, 7'h00, 7'h10, 7'h04, 7'h20, 7'h08,
        7'h40, 7'h00, 7'h00};
    vic_byte_t ra[5] = '{8'ha8, 8'hb8, 8'he8, 8'hf8, 8'h90};
    vic_byte_t rm[5] = '{8'hdf, 8'h5f, 8'h7f, 8'h7f, 8'h00};

    vic_top u_dut (.CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .PIN0_IRQ_N(pin0_n), .PIN1_IRQ_N(pin1_n), .TIMER0_OVF(evt[0]), .TIMER1_OVF(evt[1]),
        .TIMER2_EVT(evt[2]), .TIMER3_EVT(evt[3]), .RADIO_EVT(evt[4]), .CIPHER_EVT(evt[5]), .SLEEP_EVT(evt[6]),
        .UART0_IDENT(u0), .UART1_IDENT(u1), .SERIAL_LOCAL_EN(sl_en), .SERIAL_DONE(sl_done), .VOICE_EN(v_en),
        .VOICE_FLAG(v_fl), .IRQ_ACK(ack), .IRQ_RETI(reti), .IRQ_REQ(req), .IRQ_NUM(num), .IRQ_VECTOR(vec),
        .IRQ_LEVEL(lvl), .IRQ_CAUSE(cause));

    vic_core_model u_core (.clk(clk), .rst_b(rst_b), .irq_req(req), .irq_level(lvl), .lat(lat),
        .ret_go(ret_go), .irq_ack(ack), .irq_reti(reti));

    // The clock runs at 10 MHz; a hang is cut short by the cycle ceiling.
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bus cycles: one strobe cycle, read data checked in the cycle after it.
    task automatic reg_wr(input vic_byte_t a, input vic_byte_t dv);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= dv;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input vic_byte_t a, input vic_byte_t exp, input string what);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(what, 16'(exp), 16'(rdata));
    endtask

    // Raises one source, or all events in m; event sources get a one-cycle pulse of mask m.
    task automatic fire(input int src, input logic [6:0] m);
        @(posedge clk);
        case (src)
            0: pin0_n <= 1'b0;
            2: pin1_n <= 1'b0;
            4: u0 <= {uc, 1'b1};
            7: u1 <= {uc, 1'b1};
            13: sl_en <= 1'b1;
            14: v_fl <= ~v_en | 24'h1;
            default: evt <= m;
        endcase
        @(posedge clk);
        evt <= 7'h00;
    endtask

    task automatic expect_req(input int src, input logic l);
        int i;
        i = 0;
        do begin
            @(negedge clk);
            i++;
        end while (req !== 1'b1 && i < 12);
        chk("request", 16'h1, 16'(req));
        chk("number", 16'(src), 16'(num));
        chk("vector", 16'(vtab[src]), vec);
        chk("level", 16'(l), 16'(lvl));
    endtask

    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(negedge clk);
            if (req !== 1'b0) seen = 1'b1;
        end
        chk("no request", 16'h0, 16'(seen));
    endtask

    task automatic ret();
        @(posedge clk);
        ret_go <= 1'b1;
        @(posedge clk);
        ret_go <= 1'b0;
    endtask

    // Drops every source level and clears all software-visible flags.
    task automatic clr();
        @(posedge clk);
        {pin0_n, pin1_n, u0, u1, sl_en, sl_done, v_fl} <= {2'b11, 8'h00, 2'b00, 24'h0};
        reg_wr(ADDR_TIMER_CTRL, 8'h00);
        reg_wr(ADDR_EXT_FLAG, 8'h00);
        reg_wr(ADDR_EXT_CTRL, 8'h00);
    endtask

    // Main sequence: registers, masking, every source, then priority cases.
    initial begin
        void'($urandom(32'h4df3b1df));
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ra[i]) begin
            d = 8'($urandom);
            reg_rd(ra[i], 8'h00, "reset value");
            reg_wr(ra[i], d);
            reg_rd(ra[i], d & rm[i], "readback");
            reg_wr(ra[i], 8'h00);
        end
        reg_rd(ADDR_EXT_FLAG, 8'h00, "flag reset");
        reg_rd(ADDR_EXT_CTRL, 8'h00, "control reset");
        fire(9, emap[9]);
        reg_rd(ADDR_EXT_FLAG, 8'h20, "masked flag");
        reg_wr(ADDR_EN_EXT, 8'h02);
        quiet(6);
        reg_wr(ADDR_EN_BASIC, 8'h80);
        expect_req(9, 1'b0);
        repeat (6) @(posedge clk);
        clr();
        ret();
        foreach (srcs[k]) begin
            s = srcs[k];
            uc = 3'($urandom);
            lat <= 2'($urandom);
            reg_wr(ADDR_EN_BASIC, s < 8 ? 8'h80 | 8'(1 << (s < 5 ? s : 6)) : 8'h80);
            reg_wr(ADDR_EN_EXT, s < 8 ? 8'h00 : 8'(1 << (s - 8)));
            v = 24'($urandom) | 24'h1;
            if (s == 13) sl_done <= 1'b1;
            if (s == 14) {v_en, v_fl} <= {v, ~v};
            if (s > 12) quiet(6);
            fire(s, emap[s]);
            expect_req(s, 1'b0);
            repeat (6) @(posedge clk);
            if (s == 4 || s == 7) chk("cause", 16'(uc), 16'(cause));
            if (s == 12) reg_rd(ADDR_EXT_CTRL, 8'h08, "sleep flag");
            if (s == 1 || s == 3) reg_rd(ADDR_TIMER_CTRL, 8'h00, "timer flag");
            clr();
            ret();
        end
        reg_wr(ADDR_EN_BASIC, 8'h8a);
        reg_wr(ADDR_EN_EXT, 8'h00);
        reg_wr(ADDR_LVL_BASIC, 8'h08);
        fire(-1, 7'h03);
        expect_req(3, 1'b1);
        repeat (6) @(posedge clk);
        quiet(6);
        ret();
        expect_req(1, 1'b0);
        repeat (6) @(posedge clk);
        reg_rd(ADDR_TIMER_CTRL, 8'h00, "timer flags");
        ret();
        reg_wr(ADDR_EN_BASIC, 8'h80);
        reg_wr(ADDR_EN_EXT, 8'h0b);
        fire(-1, 7'h14);
        expect_req(8, 1'b0);
        repeat (6) @(posedge clk);
        reg_wr(ADDR_LVL_EXT, 8'h08);
        fire(-1, 7'h08);
        expect_req(11, 1'b1);
        repeat (6) @(posedge clk);
        clr();
        ret();
        ret();
        wrap_up();
    end
endmodule // tb_vectored_interrupt_controller
